// *** include/trig_ctrl_pkg.sv ***
`default_nettype none
package trig_ctrl_pkg;
  // ==========================================================
  // Slave-mode selection codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_RESET = 3'h4;
  localparam logic [2:0] MODE_GATED = 3'h5;
  localparam logic [2:0] MODE_TRIGGER = 3'h6;
  localparam logic [2:0] MODE_EXTCLK1 = 3'h7;
  // ==========================================================
  // Trigger-select codes
  localparam logic [2:0] TSEL_ITR1 = 3'h1;
  localparam logic [2:0] TSEL_CH1 = 3'h5;
  localparam logic [2:0] TSEL_CH2 = 3'h6;
  localparam logic [2:0] TSEL_ETR = 3'h7;
  // ==========================================================
  // Prescale and filter codes
  localparam logic [1:0] EXT_TRIGGER_PRESCALE_DIV1 = 2'h0;
  localparam logic [3:0] FILT_NONE = 4'h0;
  // ==========================================================
  // Reset values
  localparam logic RST_FLAG = 1'b0;
  localparam logic [1:0] RST_PSC = 2'h0;
  localparam logic [3:0] RST_FILT_CNT = 4'h0;
endpackage
`default_nettype wire

// *** src/timer_clock_trigger_controller.sv ***
// What this block does
// - Off mode leaves enable and update to software
// - Internal clock ticks once enable is set
// - Mode 111 counts selected trigger edges
// - Select 110 routes filtered channel 2
// - Select 101 routes filtered channel 1
// - Channel polarity bit inverts trigger sense
// - Four-bit channel filter, zero means none
// - Capture prescaler is outside trigger path
// - Clock-mode edges tick and set flag
// - All four pin and trigger inputs resynchronised by two flops
// - External clock 2 counts external pin edges
// - Two-bit prescaler divides external pin edges for external clock 2 only, not on the trigger path
// - External polarity picks rising or falling
// - Four-bit external filter, zero means none
// - Trigger mode edge starts counter, flags
// - Reset mode edge clears counter, prescaler
// - Reset mode updates when request select low
// - Gated mode counts on level, flags both
// - Gated mode stays stopped while enable low
// - Four trigger sources in the multiplexer
// - Select 001 routes internal trigger one
`default_nettype none
module timer_clock_trigger_controller (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic SRST_IN,
  // Asynchronous pins and other timers
  input wire logic TIMER_INPUT_CH1_IN,
  input wire logic TIMER_INPUT_CH2_IN,
  input wire logic EXTERNAL_TRIGGER_PIN_IN,
  input wire logic INTERNAL_TRIGGER_IN_IN,
  // Configuration
  input wire logic [2:0] SLAVE_MODE_SELECT_IN,
  input wire logic [2:0] TRIGGER_SELECT_IN,
  input wire logic EXT_CLOCK2_ENABLE_IN,
  input wire logic EXT_TRIGGER_POLARITY_IN,
  input wire logic [1:0] EXT_TRIGGER_PRESCALE_IN,
  input wire logic [3:0] EXT_TRIGGER_FILTER_IN,
  input wire logic CH1_POLARITY_IN,
  input wire logic CH2_POLARITY_IN,
  input wire logic [3:0] CH1_INPUT_FILTER_IN,
  input wire logic [3:0] CH2_INPUT_FILTER_IN,
  input wire logic UPDATE_REQUEST_SELECT_IN,
  input wire logic TRIGGER_IRQ_ENABLE_IN,
  // Software strobes
  input wire logic COUNTER_ENABLE_SET_IN,
  input wire logic COUNTER_ENABLE_CLR_IN,
  input wire logic UPDATE_GENERATE_IN,
  input wire logic TRIGGER_FLAG_CLR_IN,
  // Outputs to the time base
  output logic COUNTER_ENABLE_OUT,
  output logic PRESCALER_CLOCK_OUT,
  output logic COUNTER_CLEAR_OUT,
  output logic UPDATE_EVENT_OUT,
  output logic TRIGGER_FLAG_OUT,
  output logic TRIGGER_IRQ_OUT
);

  // ==========================================================
  // Resynchronisers
  // Raw pin levels in bit order ch1, ch2, ext pin, internal trigger
  logic [3:0] raw_in;
  logic [3:0] sync1_reg; // First stage, read only by second stage
  logic [3:0] sync2_reg; // Safe levels in the core domain
  assign raw_in = {INTERNAL_TRIGGER_IN_IN, EXTERNAL_TRIGGER_PIN_IN,
                   TIMER_INPUT_CH2_IN, TIMER_INPUT_CH1_IN};

  // Two flops per input give a fixed two-cycle latency
  // Nothing but the second stage may read sync1_reg: it can be metastable
  // The synchroniser's share of the delay from a pin edge to any response is therefore always the same
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // Digital filters for ch1, ch2 and the external pin
  // Filter field sets the count of stable samples needed
  // Glitches on a pin shorter than the field's sample count never reach the trigger logic
  logic [3:0] filt_cfg [3];
  logic [2:0] filt_lvl; // Filtered levels, one bit per filter
  // Filter fields gathered so the loop below can index them
  assign filt_cfg[0] = CH1_INPUT_FILTER_IN;
  assign filt_cfg[1] = CH2_INPUT_FILTER_IN;
  assign filt_cfg[2] = EXT_TRIGGER_FILTER_IN;

  generate
    for (genvar i = 0; i < 3; i++) begin : g_filt
      logic [3:0] cnt_reg; // Stable-sample counter
      logic lvl_reg; // Level this filter has accepted
      // Each filter owns its level flop, so no vector has two writers
      assign filt_lvl[i] = lvl_reg;
      // A new level is taken only after N agreeing samples
      // Trade-off: a field of N delays every edge by N-1 extra cycles
      always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
          cnt_reg <= trig_ctrl_pkg::RST_FILT_CNT;
          lvl_reg <= 1'b0;
        end else if (filt_cfg[i] == trig_ctrl_pkg::FILT_NONE) begin
          cnt_reg <= trig_ctrl_pkg::RST_FILT_CNT;
          lvl_reg <= sync2_reg[i];
        end else if (sync2_reg[i] == lvl_reg) begin
          // Any agreeing sample restarts the count
          cnt_reg <= trig_ctrl_pkg::RST_FILT_CNT;
        end else if (cnt_reg + 4'h1 >= filt_cfg[i]) begin
          cnt_reg <= trig_ctrl_pkg::RST_FILT_CNT;
          lvl_reg <= sync2_reg[i];
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Polarity and trigger multiplexer
  // Capture prescaler and source select never enter here
  // Polarity is a plain inversion, so a level and its edges flip together
  logic ti1_lvl;
  logic ti2_lvl;
  logic etr_lvl;
  assign ti1_lvl = filt_lvl[0] ^ CH1_POLARITY_IN;
  assign ti2_lvl = filt_lvl[1] ^ CH2_POLARITY_IN;
  assign etr_lvl = filt_lvl[2] ^ EXT_TRIGGER_POLARITY_IN;

  // Decode of the trigger source; reserved codes give no trigger
  // A reserved code reads as a quiet low, so no edge can appear on it
  function automatic logic [1:0] trig_pick(input logic [2:0] sel);
    unique case (sel)
      trig_ctrl_pkg::TSEL_ITR1: trig_pick = 2'h1;
      trig_ctrl_pkg::TSEL_CH1: trig_pick = 2'h1;
      trig_ctrl_pkg::TSEL_CH2: trig_pick = 2'h1;
      trig_ctrl_pkg::TSEL_ETR: trig_pick = 2'h1;
      default: trig_pick = 2'h0;
    endcase
  endfunction

  // The internal trigger is synchronised too but skips the filter flop, so with filters at zero it arrives one cycle before the other three
  logic trig_lvl; // Selected trigger input level
  logic trig_valid; // Select code names a real source
  always_comb begin
    trig_valid = trig_pick(TRIGGER_SELECT_IN) == 2'h1;
    unique case (TRIGGER_SELECT_IN)
      trig_ctrl_pkg::TSEL_ITR1: trig_lvl = sync2_reg[3];
      trig_ctrl_pkg::TSEL_CH1: trig_lvl = ti1_lvl;
      trig_ctrl_pkg::TSEL_CH2: trig_lvl = ti2_lvl;
      trig_ctrl_pkg::TSEL_ETR: trig_lvl = etr_lvl;
      default: trig_lvl = 1'b0;
    endcase
  end

  // ==========================================================
  // Edge detection
  // Previous levels, one cycle behind the live ones
  logic trig_prev_reg;
  logic etr_prev_reg;
  // Loading the live level in reset keeps an inverted input from faking an edge
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      trig_prev_reg <= trig_lvl;
      etr_prev_reg <= etr_lvl;
    end else begin
      trig_prev_reg <= trig_lvl;
      etr_prev_reg <= etr_lvl;
    end
  end
  // Gated mode needs both edges; the clock paths need only the rise
  logic trig_rise;
  logic trig_fall;
  logic etr_rise;
  assign trig_rise = trig_valid & trig_lvl & ~trig_prev_reg;
  assign trig_fall = trig_valid & ~trig_lvl & trig_prev_reg;
  // Pin clock edges are the rises of the polarity-adjusted level
  assign etr_rise = etr_lvl & ~etr_prev_reg;

  // ==========================================================
  // Mode decode
  // Codes 001 to 011 match none of these and fall back to internal clocking
  logic mode_reset;
  logic mode_gated;
  logic mode_trig;
  logic mode_ext1;
  assign mode_reset = SLAVE_MODE_SELECT_IN == trig_ctrl_pkg::MODE_RESET;
  assign mode_gated = SLAVE_MODE_SELECT_IN == trig_ctrl_pkg::MODE_GATED;
  assign mode_trig = SLAVE_MODE_SELECT_IN == trig_ctrl_pkg::MODE_TRIGGER;
  assign mode_ext1 = SLAVE_MODE_SELECT_IN == trig_ctrl_pkg::MODE_EXTCLK1;

  // ==========================================================
  // External trigger prescaler: pass one of every 2**N edges
  logic [2:0] ext_trigger_prescale_cnt_reg;
  logic [2:0] ext_trigger_prescale_limit;
  logic etr_tick;
  // Limit is 2**N minus one, so the count wraps after 2**N edges
  // Changing the ratio while edges arrive may pass one edge early
  assign ext_trigger_prescale_limit = 3'((4'h1 << EXT_TRIGGER_PRESCALE_IN) - 4'h1);
  assign etr_tick = etr_rise & (ext_trigger_prescale_cnt_reg >= ext_trigger_prescale_limit);
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      ext_trigger_prescale_cnt_reg <= 3'(trig_ctrl_pkg::RST_PSC);
    end else if (EXT_TRIGGER_PRESCALE_IN == trig_ctrl_pkg::EXT_TRIGGER_PRESCALE_DIV1) begin
      ext_trigger_prescale_cnt_reg <= 3'h0;
    end else if (etr_tick) begin
      ext_trigger_prescale_cnt_reg <= 3'h0;
    end else if (etr_rise) begin
      ext_trigger_prescale_cnt_reg <= ext_trigger_prescale_cnt_reg + 3'h1;
    end
  end

  // ==========================================================
  // Counter enable
  // Software owns it; trigger mode may also set it
  // A trigger start wins over a software clear in the same cycle
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      COUNTER_ENABLE_OUT <= 1'b0;
    end else if (mode_trig && trig_rise) begin
      COUNTER_ENABLE_OUT <= 1'b1;
    end else if (COUNTER_ENABLE_SET_IN) begin
      COUNTER_ENABLE_OUT <= 1'b1;
    end else if (COUNTER_ENABLE_CLR_IN) begin
      COUNTER_ENABLE_OUT <= 1'b0;
    end
  end

  // ==========================================================
  // Prescaler clock tick (one-cycle pulse per count)
  // Priority follows the order in which the clock sources override
  logic tick_next;
  always_comb begin
    if (!COUNTER_ENABLE_OUT) begin
      tick_next = 1'b0;
    end else if (EXT_CLOCK2_ENABLE_IN) begin
      // Pin clock wins over slave mode; gating still applies
      tick_next = etr_tick & (~mode_gated | trig_lvl);
    end else if (mode_ext1) begin
      tick_next = trig_rise;
    end else if (mode_gated) begin
      tick_next = trig_valid & trig_lvl;
    end else begin
      // Internal clock: off, reset, trigger and reserved modes
      tick_next = 1'b1;
    end
  end
  // Registered so the time base sees a clean one-cycle tick
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      PRESCALER_CLOCK_OUT <= 1'b0;
    end else begin
      PRESCALER_CLOCK_OUT <= tick_next;
    end
  end

  // ==========================================================
  // Counter clear and update event
  // Reset-mode clear also restarts the prescaler
  // Both pulses last one cycle; the time base must act on them at once
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      COUNTER_CLEAR_OUT <= 1'b0;
      UPDATE_EVENT_OUT <= 1'b0;
    end else begin
      COUNTER_CLEAR_OUT <= (mode_reset & trig_rise) | UPDATE_GENERATE_IN;
      // Software update strobe is self-clearing by being a pulse
      UPDATE_EVENT_OUT <= UPDATE_GENERATE_IN |
        (mode_reset & trig_rise & ~UPDATE_REQUEST_SELECT_IN);
    end
  end

  // ==========================================================
  // Trigger flag and request; a set beats a clear
  // The request copies the next flag value, so both move on one edge
  logic flag_set;
  assign flag_set = ((mode_trig | mode_reset | mode_ext1) & trig_rise) |
                    (mode_gated & COUNTER_ENABLE_OUT & (trig_rise | trig_fall));
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      TRIGGER_FLAG_OUT <= trig_ctrl_pkg::RST_FLAG;
    end else if (flag_set) begin
      TRIGGER_FLAG_OUT <= 1'b1;
    end else if (TRIGGER_FLAG_CLR_IN) begin
      TRIGGER_FLAG_OUT <= 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      TRIGGER_IRQ_OUT <= 1'b0;
    end else begin
      TRIGGER_IRQ_OUT <= (flag_set | (TRIGGER_FLAG_OUT & ~TRIGGER_FLAG_CLR_IN))
        & TRIGGER_IRQ_ENABLE_IN;
    end
  end

endmodule
`default_nettype wire

// *** sim/trig_ctrl_chk.sv ***
`default_nettype none
// ==========================================================
// Port-level checks of the clock and trigger controller
module trig_ctrl_chk (
  // Clock, reset, configuration and software strobes
  input wire logic CORE_CLK_IN, SRST_IN, EXT_CLOCK2_ENABLE_IN, UPDATE_REQUEST_SELECT_IN,
  input wire logic [2:0] SLAVE_MODE_SELECT_IN,
  input wire logic TRIGGER_IRQ_ENABLE_IN, COUNTER_ENABLE_SET_IN, COUNTER_ENABLE_CLR_IN,
  input wire logic UPDATE_GENERATE_IN, TRIGGER_FLAG_CLR_IN,
  // Watched outputs
  input wire logic COUNTER_ENABLE_OUT, PRESCALER_CLOCK_OUT, COUNTER_CLEAR_OUT,
  input wire logic UPDATE_EVENT_OUT, TRIGGER_FLAG_OUT, TRIGGER_IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SRST_IN);
  // Request follows flag and enable; guard the cycle where the enable moves
  irq_is_and_a: assert property ($stable(TRIGGER_IRQ_ENABLE_IN) |->
    TRIGGER_IRQ_OUT == (TRIGGER_FLAG_OUT && TRIGGER_IRQ_ENABLE_IN)) else $error("irq wrong");
  flag_holds_a: assert property (TRIGGER_FLAG_OUT && !TRIGGER_FLAG_CLR_IN |=>
    TRIGGER_FLAG_OUT) else $error("flag lost");
  flag_clears_a: assert property (TRIGGER_FLAG_CLR_IN && $stable(SLAVE_MODE_SELECT_IN) &&
    SLAVE_MODE_SELECT_IN == trig_ctrl_pkg::MODE_OFF |=> !TRIGGER_FLAG_OUT) else $error("flag kept");
  // Only a defined trigger mode may raise the flag
  flag_cause_a: assert property ($rose(TRIGGER_FLAG_OUT) |->
    $past(SLAVE_MODE_SELECT_IN) >= 3'h4) else $error("flag in idle mode");
  enable_set_a: assert property (COUNTER_ENABLE_SET_IN |=> COUNTER_ENABLE_OUT)
    else $error("enable not set");
  enable_clr_a: assert property (COUNTER_ENABLE_CLR_IN && !COUNTER_ENABLE_SET_IN &&
    SLAVE_MODE_SELECT_IN == trig_ctrl_pkg::MODE_OFF |=> !COUNTER_ENABLE_OUT)
    else $error("enable not cleared");
  tick_internal_a: assert property ((!SLAVE_MODE_SELECT_IN[2] && !EXT_CLOCK2_ENABLE_IN &&
    COUNTER_ENABLE_OUT) [*2] |=> PRESCALER_CLOCK_OUT) else $error("internal tick missing");
  tick_idle_a: assert property ((!COUNTER_ENABLE_OUT) [*2] |=> !PRESCALER_CLOCK_OUT)
    else $error("tick while disabled");
  soft_update_a: assert property (UPDATE_GENERATE_IN |=>
    UPDATE_EVENT_OUT && COUNTER_CLEAR_OUT) else $error("soft update missing");
  reset_update_a: assert property (COUNTER_CLEAR_OUT && !$past(UPDATE_GENERATE_IN) &&
    !$past(UPDATE_REQUEST_SELECT_IN) |-> UPDATE_EVENT_OUT) else $error("reset update missing");
  clear_cause_a: assert property (COUNTER_CLEAR_OUT |-> $past(UPDATE_GENERATE_IN) ||
    $past(SLAVE_MODE_SELECT_IN) == trig_ctrl_pkg::MODE_RESET) else $error("stray clear");
endmodule
`default_nettype wire

// *** sim/pin_model.sv ***
`default_nettype none
// ==========================================================
// Far side: pins and the other timer's trigger, stepped on the edge
module pin_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Requested levels and driven pins
  input wire logic [3:0] lvl_in,
  output logic [3:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Changing right at the edge is the worst alignment for the synchroniser
  always_ff @(posedge clk_in) begin
    if (rst_in) pin_out <= 4'h0;
    else pin_out <= lvl_in;
  end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Stimulus, outputs and tallies
  logic clk = '0, rst = 1'h1, ece = '0, epol = '0, update_request_select = '0, ien = 1'h1, p1 = '0, p2 = '0;
  logic eset = '0, eclr = '0, ug = '0, fclr = '0;
  logic [2:0] slave_mode_select = '0, tsel = '0;
  logic [1:0] eps = '0;
  logic [3:0] ef = '0, f1 = '0, f2 = '0, lvl = '0, pin;
  logic en_o, tick_o, clr_o, upd_o, flag_o, irq_o;
  int miscompares = 0, checked = 0, ticks = 0, upds = 0, clrs = 0;
  initial forever #12.5 clk = ~clk;
  pin_model far (.clk_in(clk), .rst_in(rst), .lvl_in(lvl), .pin_out(pin));
  timer_clock_trigger_controller dut (.CORE_CLK_IN(clk), .SRST_IN(rst),
    .TIMER_INPUT_CH1_IN(pin[0]), .TIMER_INPUT_CH2_IN(pin[1]), .EXTERNAL_TRIGGER_PIN_IN(pin[2]),
    .INTERNAL_TRIGGER_IN_IN(pin[3]), .SLAVE_MODE_SELECT_IN(slave_mode_select), .TRIGGER_SELECT_IN(tsel),
    .EXT_CLOCK2_ENABLE_IN(ece), .EXT_TRIGGER_POLARITY_IN(epol), .EXT_TRIGGER_PRESCALE_IN(eps),
    .EXT_TRIGGER_FILTER_IN(ef), .CH1_POLARITY_IN(p1), .CH2_POLARITY_IN(p2),
    .CH1_INPUT_FILTER_IN(f1), .CH2_INPUT_FILTER_IN(f2), .UPDATE_REQUEST_SELECT_IN(update_request_select),
    .TRIGGER_IRQ_ENABLE_IN(ien), .COUNTER_ENABLE_SET_IN(eset), .COUNTER_ENABLE_CLR_IN(eclr),
    .UPDATE_GENERATE_IN(ug), .TRIGGER_FLAG_CLR_IN(fclr), .COUNTER_ENABLE_OUT(en_o),
    .PRESCALER_CLOCK_OUT(tick_o), .COUNTER_CLEAR_OUT(clr_o), .UPDATE_EVENT_OUT(upd_o),
    .TRIGGER_FLAG_OUT(flag_o), .TRIGGER_IRQ_OUT(irq_o));
  // Tally one-cycle pulses on the edge where they stand
  always @(posedge clk) begin
    if (tick_o === 1'h1) ticks++;
    if (upd_o === 1'h1) upds++;
    if (clr_o === 1'h1) clrs++;
  end
  // ==========================================================
  // Access tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask
  // One-cycle software strobe: 0 enable set, 1 enable clear, 2 update, 3 flag clear
  task automatic go(input int k);
    case (k)
      0: eset = 1'h1;
      1: eclr = 1'h1;
      2: ug = 1'h1;
      default: fclr = 1'h1;
    endcase
    cyc(1);
    {eset, eclr, ug, fclr} = 4'h0;
    cyc(1);
  endtask
  // Eight cycles cover sync, filter and output latency
  task automatic pin_to(input int b, input logic v);
    lvl[b] = v;
    cyc(8);
  endtask
  task automatic zero();
    ticks = 0;
    upds = 0;
    clrs = 0;
  endtask
  // Stop the counter and drop the flag before a mode change
  task automatic cfg(input logic [2:0] m, input logic [2:0] t);
    go(1);
    go(3);
    slave_mode_select = m;
    tsel = t;
    cyc(8);
    zero();
  endtask
  task automatic end_sim();
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'h0;
    cfg(trig_ctrl_pkg::MODE_OFF, 3'h0);
    go(0);
    zero();
    cyc(10);
    chk(1, en_o);
    chk(10, ticks);
    go(1);
    cyc(2);
    zero();
    cyc(5);
    chk(0, ticks);
    go(2);
    chk(1, upds);
    cfg(trig_ctrl_pkg::MODE_EXTCLK1, trig_ctrl_pkg::TSEL_CH2);
    go(0);
    zero();
    pin_to(1, 1'h1);
    chk(1, ticks);
    chk(1, irq_o);
    go(3);
    chk(0, flag_o);
    p2 = 1'h1;
    pin_to(1, 1'h0);
    zero();
    pin_to(1, 1'h1);
    pin_to(1, 1'h0);
    chk(1, ticks);
    f2 = 4'h3;
    zero();
    lvl[1] = 1'h1;
    cyc(1);
    pin_to(1, 1'h0);
    chk(0, ticks);
    p2 = 1'h0;
    cfg(trig_ctrl_pkg::MODE_RESET, trig_ctrl_pkg::TSEL_CH1);
    go(0);
    zero();
    lvl[0] = 1'h1;
    cyc(4);
    chk(0, clr_o);
    cyc(1);
    chk(1, clr_o);
    cyc(3);
    chk(1, clrs);
    chk(1, upds);
    update_request_select = 1'h1;
    pin_to(0, 1'h0);
    zero();
    pin_to(0, 1'h1);
    chk(0, upds);
    cfg(trig_ctrl_pkg::MODE_GATED, trig_ctrl_pkg::TSEL_ITR1);
    pin_to(3, 1'h1);
    chk(0, ticks);
    go(0);
    zero();
    cyc(10);
    chk(10, ticks);
    go(3);
    pin_to(3, 1'h0);
    zero();
    cyc(5);
    chk(0, ticks);
    chk(1, flag_o);
    ien = 1'h0;
    cyc(1);
    chk(0, irq_o);
    ien = 1'h1;
    cfg(trig_ctrl_pkg::MODE_TRIGGER, trig_ctrl_pkg::TSEL_CH2);
    pin_to(1, 1'h1);
    chk(1, en_o);
    chk(1, flag_o);
    ece = 1'h1;
    eps = 2'h1;
    cfg(trig_ctrl_pkg::MODE_OFF, 3'h0);
    go(0);
    zero();
    repeat (4) begin
      pin_to(2, 1'h1);
      pin_to(2, 1'h0);
    end
    chk(2, ticks);
    eps = 2'h0;
    epol = 1'h1;
    cyc(8);
    zero();
    pin_to(2, 1'h1);
    pin_to(2, 1'h0);
    chk(1, ticks);
    ef = 4'h3;
    zero();
    lvl[2] = 1'h1;
    cyc(1);
    pin_to(2, 1'h0);
    chk(0, ticks);
    ef = 4'h0;
    ece = 1'h0;
    epol = 1'h0;
    cfg(trig_ctrl_pkg::MODE_RESET, trig_ctrl_pkg::TSEL_ETR);
    pin_to(2, 1'h1);
    chk(1, clrs);
    lvl = 4'h0;
    cfg(trig_ctrl_pkg::MODE_TRIGGER, 3'h2);
    lvl = 4'hf;
    cyc(8);
    chk(0, flag_o);
    chk(0, en_o);
    end_sim();
  end
  // Watchdog well beyond the expected run of about 350 cycles
  initial begin
    #60us;
    miscompares++;
    end_sim();
  end
endmodule
// Port-level checker, bound into every instance of the controller
bind timer_clock_trigger_controller trig_ctrl_chk chk (.CORE_CLK_IN(CORE_CLK_IN),
  .SRST_IN(SRST_IN), .EXT_CLOCK2_ENABLE_IN(EXT_CLOCK2_ENABLE_IN),
  .UPDATE_REQUEST_SELECT_IN(UPDATE_REQUEST_SELECT_IN), .SLAVE_MODE_SELECT_IN(SLAVE_MODE_SELECT_IN),
  .TRIGGER_IRQ_ENABLE_IN(TRIGGER_IRQ_ENABLE_IN), .COUNTER_ENABLE_SET_IN(COUNTER_ENABLE_SET_IN),
  .COUNTER_ENABLE_CLR_IN(COUNTER_ENABLE_CLR_IN), .UPDATE_GENERATE_IN(UPDATE_GENERATE_IN),
  .TRIGGER_FLAG_CLR_IN(TRIGGER_FLAG_CLR_IN), .COUNTER_ENABLE_OUT(COUNTER_ENABLE_OUT),
  .PRESCALER_CLOCK_OUT(PRESCALER_CLOCK_OUT), .COUNTER_CLEAR_OUT(COUNTER_CLEAR_OUT),
  .UPDATE_EVENT_OUT(UPDATE_EVENT_OUT), .TRIGGER_FLAG_OUT(TRIGGER_FLAG_OUT),
  .TRIGGER_IRQ_OUT(TRIGGER_IRQ_OUT));
`default_nettype wire
